// ===== ppc_counter.sv
// prescaled up/down pulse counter with menu, limits and retention
`timescale 1ns/1ps
module ppc_counter #(
   parameter int unsigned COUNT_W = ppc_pkg::COUNT_W,
   parameter int unsigned DISP_W  = ppc_pkg::DISP_W,
   parameter int unsigned DIV_W   = ppc_pkg::DIV_W
) (
   input  wire logic                       i_clock,
   input  wire logic                       i_sys_rst,
   input  wire logic                       i_pulse_pin,
   input  wire logic                       i_reset_contact_n,
   input  wire logic                       i_menu_confirm,
   input  wire ppc_pkg::ppc_cfg_s          i_cfg_edit,
   input  wire logic                       i_retain_valid,
   input  wire logic [ppc_pkg::COUNT_W-1:0] i_retain_count,
   output ppc_pkg::ppc_menu_e              o_menu_entry,
   output ppc_pkg::ppc_cfg_s               o_cfg,
   output logic [ppc_pkg::COUNT_W-1:0]     o_count,
   output logic                            o_retain_write,
   output logic                            o_over_range,
   output logic                            o_under_range,
   output ppc_pkg::ppc_disp_s              o_display
);

   initial begin
      if (COUNT_W != ppc_pkg::COUNT_W || DISP_W != ppc_pkg::DISP_W
          || DIV_W != ppc_pkg::DIV_W) begin
         $error("ppc_counter: widths must match the package");
      end
   end

   logic                 rc_sync1_r;
   logic                 rc_sync2_r;
   logic                 confirm_prev_r;
   logic                 confirm_pulse;
   logic                 restore_pending_r;
   logic                 dir_reload;
   logic                 count_pulse;
   logic                 hold;
   logic [COUNT_W-1:0]   start_value;
   logic [COUNT_W-1:0]   count_r;
   logic                 over_r;
   logic                 under_r;
   logic                 scale_busy;
   logic                 scale_done;
   logic [DISP_W-1:0]    scaled;
   logic [COUNT_W-1:0]   count_shown;

   ////////////////////////////////////////////////////////////////////////////////
   // reset contact synchroniser, active low at the pin
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         rc_sync1_r <= 1'b1;
         rc_sync2_r <= 1'b1;
      end else begin
         rc_sync1_r <= i_reset_contact_n;
         rc_sync2_r <= rc_sync1_r;
      end
   end

   assign hold = ~rc_sync2_r;

   ////////////////////////////////////////////////////////////////////////////////
   // configuration menu, entries applied on confirm
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         confirm_prev_r <= 1'b0;
      end else begin
         confirm_prev_r <= i_menu_confirm;
      end
   end

   assign confirm_pulse = i_menu_confirm & ~confirm_prev_r;

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_menu_entry <= ppc_pkg::PPC_MENU_INPUT_TYPE;
      end else if (confirm_pulse) begin
         case (o_menu_entry)
            ppc_pkg::PPC_MENU_INPUT_TYPE: o_menu_entry <= ppc_pkg::PPC_MENU_SOURCE;
            ppc_pkg::PPC_MENU_SOURCE:     o_menu_entry <= ppc_pkg::PPC_MENU_EDGE;
            ppc_pkg::PPC_MENU_EDGE:       o_menu_entry <= ppc_pkg::PPC_MENU_DIVISOR;
            ppc_pkg::PPC_MENU_DIVISOR:    o_menu_entry <= ppc_pkg::PPC_MENU_LIMIT;
            ppc_pkg::PPC_MENU_LIMIT:      o_menu_entry <= ppc_pkg::PPC_MENU_DP;
            ppc_pkg::PPC_MENU_DP:         o_menu_entry <= ppc_pkg::PPC_MENU_DISP_HI;
            ppc_pkg::PPC_MENU_DISP_HI:    o_menu_entry <= ppc_pkg::PPC_MENU_LIMIT_MODE;
            default:                      o_menu_entry <= ppc_pkg::PPC_MENU_INPUT_TYPE;
         endcase
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_cfg.count_down             <= 1'b0;
         o_cfg.source                 <= ppc_pkg::PPC_SRC_TTL;
         o_cfg.falling_edge           <= 1'b0;
         o_cfg.divisor                <= ppc_pkg::DIV_RST;
         o_cfg.upper_count_limit      <= ppc_pkg::LIMIT_RST;
         o_cfg.decimal_point_position <= ppc_pkg::DP_RST;
         o_cfg.display_high_value     <= ppc_pkg::DISP_HI_RST;
         o_cfg.range_limit_mode       <= ppc_pkg::PPC_LIMIT_OFF;
      end else if (confirm_pulse) begin
         case (o_menu_entry)
            ppc_pkg::PPC_MENU_INPUT_TYPE: o_cfg.count_down <= i_cfg_edit.count_down;
            ppc_pkg::PPC_MENU_SOURCE:     o_cfg.source <= i_cfg_edit.source;
            ppc_pkg::PPC_MENU_EDGE:       o_cfg.falling_edge <= i_cfg_edit.falling_edge;
            ppc_pkg::PPC_MENU_DIVISOR:    o_cfg.divisor <= i_cfg_edit.divisor;
            ppc_pkg::PPC_MENU_LIMIT:
               o_cfg.upper_count_limit <= i_cfg_edit.upper_count_limit;
            ppc_pkg::PPC_MENU_DP:
               o_cfg.decimal_point_position <= i_cfg_edit.decimal_point_position;
            ppc_pkg::PPC_MENU_DISP_HI:
               o_cfg.display_high_value <= i_cfg_edit.display_high_value;
            default:
               o_cfg.range_limit_mode <= i_cfg_edit.range_limit_mode;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // edge select and prescaler
   ppc_edge_prescaler #(
      .DIV_W (DIV_W)
   ) u_prescaler (
      .i_clock        (i_clock),
      .i_sys_rst      (i_sys_rst),
      .i_pulse_pin    (i_pulse_pin),
      .i_falling_edge (o_cfg.falling_edge),
      .i_divisor      (o_cfg.divisor),
      .i_hold         (hold),
      .o_count_pulse  (count_pulse)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // counter
   assign start_value = o_cfg.count_down ? o_cfg.upper_count_limit : ppc_pkg::COUNT_ZERO;

   // confirming the input type reloads the count for the new direction
   assign dir_reload = confirm_pulse && (o_menu_entry == ppc_pkg::PPC_MENU_INPUT_TYPE);

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         restore_pending_r <= 1'b1;
      end else begin
         restore_pending_r <= 1'b0;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         count_r <= ppc_pkg::COUNT_ZERO;
         over_r  <= 1'b0;
         under_r <= 1'b0;
      end else if (restore_pending_r) begin
         count_r <= i_retain_valid ? i_retain_count : start_value;
         over_r  <= 1'b0;
         under_r <= 1'b0;
      end else if (hold) begin
         count_r <= start_value;
         over_r  <= 1'b0;
         under_r <= 1'b0;
      end else if (dir_reload) begin
         count_r <= i_cfg_edit.count_down ? o_cfg.upper_count_limit : ppc_pkg::COUNT_ZERO;
         over_r  <= 1'b0;
         under_r <= 1'b0;
      end else if (count_pulse) begin
         if (!o_cfg.count_down) begin
            if (o_cfg.range_limit_mode != ppc_pkg::PPC_LIMIT_OFF
                && count_r >= o_cfg.upper_count_limit) begin
               over_r <= 1'b1;
            end else if (count_r != ppc_pkg::COUNT_ABS_MAX) begin
               count_r <= count_r + 1'b1;
            end
         end else begin
            if (count_r == ppc_pkg::COUNT_ZERO) begin
               under_r <= 1'b1;
            end else begin
               count_r <= count_r - 1'b1;
            end
         end
      end
   end

   assign o_count        = count_r;
   assign o_over_range   = over_r;
   assign o_under_range  = under_r;
   // every cause of a count change strobes the store
   assign o_retain_write = count_pulse | hold | restore_pending_r | dir_reload;

   ////////////////////////////////////////////////////////////////////////////////
   // display scaling and limit presentation
   always_comb begin
      count_shown = count_r;
      if (o_cfg.range_limit_mode == ppc_pkg::PPC_LIMIT_CLAMP && over_r) begin
         count_shown = o_cfg.upper_count_limit;
      end else if (o_cfg.range_limit_mode == ppc_pkg::PPC_LIMIT_CLAMP && under_r) begin
         count_shown = ppc_pkg::COUNT_ZERO;
      end
   end

   ppc_scaler #(
      .COUNT_W (COUNT_W),
      .DISP_W  (DISP_W)
   ) u_scaler (
      .i_clock     (i_clock),
      .i_sys_rst   (i_sys_rst),
      .i_start     (~scale_busy),
      .i_count     (count_shown),
      .i_limit     (o_cfg.upper_count_limit),
      .i_disp_high (o_cfg.display_high_value),
      .o_busy      (scale_busy),
      .o_done      (scale_done),
      .o_value     (scaled)
   );

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_display.value                  <= '0;
         o_display.decimal_point_position <= ppc_pkg::DP_RST;
         o_display.error                  <= 1'b0;
      end else if (scale_done) begin
         o_display.value <= (scaled > ppc_pkg::DISP_MAX_VAL) ? ppc_pkg::DISP_MAX_VAL
                                                             : scaled;
         o_display.decimal_point_position <= o_cfg.decimal_point_position;
         o_display.error <= (o_cfg.range_limit_mode == ppc_pkg::PPC_LIMIT_ERROR
                             && (over_r || under_r))
                            || (count_r == ppc_pkg::COUNT_ABS_MAX);
      end
   end

endmodule

// ===== ppc_pkg.sv
// package: shared types and constants of the prescaled pulse counter
package ppc_pkg;

   localparam int unsigned COUNT_W       = 24;
   localparam int unsigned DISP_W        = 20;
   localparam int unsigned DIV_W         = 16;
   localparam int unsigned DP_W          = 2;
   localparam logic [COUNT_W-1:0] COUNT_ZERO   = 24'h000000;
   localparam logic [COUNT_W-1:0] COUNT_ABS_MAX = 24'hffffff;
   localparam logic [DISP_W-1:0]  DISP_MAX_VAL = 20'h0270f;
   localparam logic [DIV_W-1:0]   DIV_RST      = 16'h0001;
   localparam logic [COUNT_W-1:0] LIMIT_RST    = 24'h002710;
   localparam logic [DISP_W-1:0]  DISP_HI_RST  = 20'h0270f;
   localparam logic [DP_W-1:0]    DP_RST       = 2'h0;

   typedef enum logic [1:0] {
      PPC_LIMIT_OFF,
      PPC_LIMIT_ERROR,
      PPC_LIMIT_CLAMP
   } ppc_limit_e;

   typedef enum logic [1:0] {
      PPC_SRC_TTL,
      PPC_SRC_SINKING,
      PPC_SRC_SOURCING
   } ppc_source_e;

   typedef enum logic [2:0] {
      PPC_MENU_INPUT_TYPE,
      PPC_MENU_SOURCE,
      PPC_MENU_EDGE,
      PPC_MENU_DIVISOR,
      PPC_MENU_LIMIT,
      PPC_MENU_DP,
      PPC_MENU_DISP_HI,
      PPC_MENU_LIMIT_MODE
   } ppc_menu_e;

   // configuration set as applied to the counter
   typedef struct packed {
      logic                count_down;
      ppc_source_e         source;
      logic                falling_edge;
      logic [DIV_W-1:0]    divisor;
      logic [COUNT_W-1:0]  upper_count_limit;
      logic [DP_W-1:0]     decimal_point_position;
      logic [DISP_W-1:0]   display_high_value;
      ppc_limit_e          range_limit_mode;
   } ppc_cfg_s;

   // presented value
   typedef struct packed {
      logic [DISP_W-1:0] value;
      logic [DP_W-1:0]   decimal_point_position;
      logic              error;
   } ppc_disp_s;

endpackage

// ===== ppc_edge_prescaler.sv
// edge detection and prescaling of the counting input
`timescale 1ns/1ps
module ppc_edge_prescaler #(
   parameter int unsigned DIV_W = 16
) (
   input  wire logic             i_clock,
   input  wire logic             i_sys_rst,
   input  wire logic             i_pulse_pin,
   input  wire logic             i_falling_edge,
   input  wire logic [DIV_W-1:0] i_divisor,
   input  wire logic             i_hold,
   output logic                  o_count_pulse
);

   initial begin
      if (DIV_W < 1 || DIV_W > 31) $error("ppc_edge_prescaler: bad DIV_W");
   end

   logic             sync1_r;
   logic             sync2_r;
   logic             prev_r;
   logic [DIV_W-1:0] div_cnt_r;
   logic             edge_seen;
   logic             div_hit;

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r  <= 1'b0;
      end else begin
         sync1_r <= i_pulse_pin;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   assign edge_seen = i_falling_edge ? (prev_r & ~sync2_r) : (~prev_r & sync2_r);

   // divisor of zero behaves as one
   assign div_hit = (div_cnt_r + 1'b1 >= i_divisor);

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || i_hold) begin
         div_cnt_r     <= '0;
         o_count_pulse <= 1'b0;
      end else begin
         o_count_pulse <= 1'b0;
         if (edge_seen) begin
            if (div_hit) begin
               div_cnt_r     <= '0;
               o_count_pulse <= 1'b1;
            end else begin
               div_cnt_r <= div_cnt_r + 1'b1;
            end
         end
      end
   end

endmodule

// ===== ppc_scaler.sv
// scaling of the count to the display range, iterative divider
`timescale 1ns/1ps
module ppc_scaler #(
   parameter int unsigned COUNT_W = 24,
   parameter int unsigned DISP_W  = 20
) (
   input  wire logic               i_clock,
   input  wire logic               i_sys_rst,
   input  wire logic               i_start,
   input  wire logic [COUNT_W-1:0] i_count,
   input  wire logic [COUNT_W-1:0] i_limit,
   input  wire logic [DISP_W-1:0]  i_disp_high,
   output logic                    o_busy,
   output logic                    o_done,
   output logic [DISP_W-1:0]       o_value
);

   localparam int unsigned PW = COUNT_W + DISP_W;
   localparam int unsigned SW = $clog2(PW + 1);

   initial begin
      if (COUNT_W < 2 || DISP_W < 2) $error("ppc_scaler: widths too small");
   end

   logic [PW-1:0]      num_r;
   logic [PW-1:0]      quo_r;
   logic [COUNT_W:0]   rem_r;
   logic [COUNT_W-1:0] den_r;
   logic [SW-1:0]      step_r;
   logic [COUNT_W:0]   rem_shift;

   assign rem_shift = {rem_r[COUNT_W-1:0], num_r[PW-1]};

   ////////////////////////////////////////////////////////////////////////////////
   // value = count * display_high / limit, restoring division one bit a cycle
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_busy  <= 1'b0;
         o_done  <= 1'b0;
         o_value <= '0;
         num_r   <= '0;
         quo_r   <= '0;
         rem_r   <= '0;
         den_r   <= '0;
         step_r  <= '0;
      end else begin
         o_done <= 1'b0;
         if (!o_busy && i_start) begin
            num_r  <= PW'(i_count) * PW'(i_disp_high);
            den_r  <= (i_limit == '0) ? COUNT_W'(1) : i_limit;
            quo_r  <= '0;
            rem_r  <= '0;
            step_r <= SW'(PW);
            o_busy <= 1'b1;
         end else if (o_busy) begin
            num_r <= {num_r[PW-2:0], 1'b0};
            if (rem_shift >= {1'b0, den_r}) begin
               rem_r <= rem_shift - {1'b0, den_r};
               quo_r <= {quo_r[PW-2:0], 1'b1};
            end else begin
               rem_r <= rem_shift;
               quo_r <= {quo_r[PW-2:0], 1'b0};
            end
            step_r <= step_r - 1'b1;
            if (step_r == SW'(1)) begin
               o_busy <= 1'b0;
               o_done <= 1'b1;
               if (rem_shift >= {1'b0, den_r}) begin
                  o_value <= (|quo_r[PW-2:DISP_W-1]) ? '1 : {quo_r[DISP_W-2:0], 1'b1};
               end else begin
                  o_value <= (|quo_r[PW-2:DISP_W-1]) ? '1 : {quo_r[DISP_W-2:0], 1'b0};
               end
            end
         end
      end
   end

endmodule

// ===== ppc_pulse_src.sv
// partner: bounce-free pulse transmitter driving the counting pin
`timescale 1ns/1ps
module ppc_pulse_src (
   input  wire logic       i_clock,
   input  wire logic       i_fire,
   input  wire logic [7:0] i_num,
   output logic            o_pin,
   output logic            o_busy
);
   logic [9:0] left_r = 10'h000;
   always @(posedge i_clock) begin
      if (i_fire) begin
         left_r <= {i_num, 2'h0};
      end else if (left_r != 10'h000) begin
         left_r <= left_r - 10'h001;
      end
   end
   // two cycles high, two low, idle low, one clean edge each way
   assign o_pin  = left_r[1];
   assign o_busy = i_fire || (left_r != 10'h000);
endmodule

// ===== ppc_counter_asserts.sv
// checker: port properties of the prescaled pulse counter
`timescale 1ns/1ps
module ppc_counter_asserts (
   input wire logic                        i_clock,
   input wire logic                        i_sys_rst,
   input wire logic                        i_pulse_pin,
   input wire logic                        i_reset_contact_n,
   input wire logic                        i_menu_confirm,
   input wire ppc_pkg::ppc_menu_e          o_menu_entry,
   input wire ppc_pkg::ppc_cfg_s           o_cfg,
   input wire logic [ppc_pkg::COUNT_W-1:0] o_count,
   input wire logic                        o_retain_write,
   input wire logic                        o_over_range,
   input wire logic                        o_under_range
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   ////////////////////////////////////////////////////////////////////////////////
   // selected edge at divisor one, away from both bounds
   sequence s_edge;
      (o_cfg.falling_edge ? $fell(i_pulse_pin) : $rose(i_pulse_pin)) && o_cfg.divisor <= 16'h0001
      && o_cfg.range_limit_mode == ppc_pkg::PPC_LIMIT_OFF && o_count > 24'h000002
      && o_count < 24'hfffff0;
   endsequence
   sequence s_quiet;
      (i_reset_contact_n && !i_menu_confirm) [*6];
   endsequence
   property p_step;
      s_edge ##0 s_quiet |-> o_count == (o_cfg.count_down ? $past(o_count, 4) - 24'h000001
                                                          : $past(o_count, 4) + 24'h000001);
   endproperty
   a_count_step: assert property (p_step)
      else $error("counted edge did not step the count by one");
   a_hold_start: assert property (
      (!i_reset_contact_n && !i_menu_confirm) [*4] |=>
      o_count == (o_cfg.count_down ? o_cfg.upper_count_limit : ppc_pkg::COUNT_ZERO))
      else $error("count not held at start value");
   a_idle_stable: assert property (
      !$past(i_sys_rst) && !o_retain_write |=> $stable(o_count))
      else $error("count moved without store strobe");
   a_over_cause: assert property ($rose(o_over_range) |-> !o_cfg.count_down
      && o_cfg.range_limit_mode != ppc_pkg::PPC_LIMIT_OFF && o_count == o_cfg.upper_count_limit)
      else $error("over-range flag without held upper bound");
   a_under_cause: assert property ($rose(o_under_range) |->
      o_cfg.count_down && o_count == ppc_pkg::COUNT_ZERO)
      else $error("under-range flag away from zero");
   a_limit_bound: assert property (!o_cfg.count_down
      && o_cfg.range_limit_mode != ppc_pkg::PPC_LIMIT_OFF && o_count >= o_cfg.upper_count_limit
      |=> o_count <= $past(o_count) || $changed(o_cfg))
      else $error("count passed the upper limit");
   a_menu_step: assert property ($changed(o_menu_entry) && !$past(i_sys_rst) |->
      o_menu_entry == ppc_pkg::ppc_menu_e'($past(o_menu_entry) + 3'h1))
      else $error("menu skipped an entry");
   a_reset_defaults: assert property (disable iff (1'b0) i_sys_rst |=>
      o_menu_entry == ppc_pkg::PPC_MENU_INPUT_TYPE && o_cfg.divisor == ppc_pkg::DIV_RST
      && o_cfg.upper_count_limit == ppc_pkg::LIMIT_RST)
      else $error("reset state wrong");
endmodule

// ===== test_prescaled_pulse_counter.sv
// testbench: table of counting cases, then hold, reset and retention cases
`timescale 1ns/1ps
module test_prescaled_pulse_counter;
   typedef struct {
      ppc_pkg::ppc_cfg_s cfg;
      logic [7:0]        num;
      logic [23:0]       cnt;
      logic              ovr;
      logic              und;
   } ppc_row_s;
   logic               i_clock;
   logic               i_sys_rst;
   logic               pin;
   logic               i_reset_contact_n;
   logic               i_menu_confirm;
   ppc_pkg::ppc_cfg_s  i_cfg_edit;
   logic               i_retain_valid;
   logic [23:0]        i_retain_count;
   ppc_pkg::ppc_menu_e menu;
   ppc_pkg::ppc_cfg_s  cfg;
   logic [23:0]        count;
   logic               over;
   logic               under;
   ppc_pkg::ppc_disp_s disp;
   logic               fire;
   logic [7:0]         num;
   logic               busy;
   logic               store;
   int                 error_cnt = 0;
   int                 tests_run = 0;
   int                 cyc = 0;
   ppc_row_s           rows[8];
   ppc_counter uut (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_pulse_pin(pin),
      .i_reset_contact_n(i_reset_contact_n), .i_menu_confirm(i_menu_confirm),
      .i_cfg_edit(i_cfg_edit), .i_retain_valid(i_retain_valid), .i_retain_count(i_retain_count),
      .o_menu_entry(menu), .o_cfg(cfg), .o_count(count), .o_retain_write(store),
      .o_over_range(over), .o_under_range(under), .o_display(disp)
   );
   ppc_pulse_src src (.i_clock(i_clock), .i_fire(fire), .i_num(num), .o_pin(pin), .o_busy(busy));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   task automatic check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic pulses(input logic [7:0] n);
      fire <= 1'b1;
      num <= n;
      tick(1);
      fire <= 1'b0;
      while (busy === 1'b1) tick(1);
      tick(8);
   endtask
   task automatic set_cfg(input ppc_pkg::ppc_cfg_s c);
      i_cfg_edit <= c;
      for (int k = 0; k < 8; k++) begin
         check(menu === ppc_pkg::ppc_menu_e'(k), "menu entry");
         i_menu_confirm <= 1'b1;
         tick(3);
         i_menu_confirm <= 1'b0;
         tick(3);
      end
      check(menu === ppc_pkg::PPC_MENU_INPUT_TYPE && cfg === c, "menu config");
   endtask
   task automatic hold(input logic [23:0] start);
      i_reset_contact_n <= 1'b0;
      tick(4);
      check(count === start && over === 1'b0 && under === 1'b0, "contact hold");
      check(store === 1'b1, "store strobe during hold");
      i_reset_contact_n <= 1'b1;
      tick(4);
   endtask
   task automatic do_reset(input logic v, input logic [23:0] r);
      i_retain_valid <= v;
      i_retain_count <= r;
      i_sys_rst <= 1'b1;
      tick(2);
      i_sys_rst <= 1'b0;
      tick(3);
   endtask
   // mode 0 off, 1 error, 2 clamp; f holds over and under flags
   function automatic ppc_row_s mk(input logic dn, input logic fe, input logic [15:0] dv,
                                   input logic [23:0] lm, input logic [1:0] md,
                                   input logic [7:0] n, input logic [23:0] c, input logic [1:0] f);
      ppc_row_s r;
      r.cfg = '0;
      r.cfg.count_down = dn;
      r.cfg.falling_edge = fe;
      r.cfg.divisor = dv;
      r.cfg.upper_count_limit = lm;
      r.cfg.range_limit_mode = ppc_pkg::ppc_limit_e'(md);
      r.num = n;
      r.cnt = c;
      r.ovr = f[1];
      r.und = f[0];
      return r;
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         $display("ERROR %0t run timed out", $time);
         close_out();
      end
   end
   initial begin
      logic [47:0] q;
      logic        e;
      i_sys_rst = 1'b1;
      i_reset_contact_n = 1'b1;
      i_menu_confirm = 1'b0;
      i_cfg_edit = '0;
      i_retain_valid = 1'b0;
      i_retain_count = 24'h000000;
      fire = 1'b0;
      num = 8'h00;
      rows[0] = mk(1'h0, 1'h0, 16'h0001, 24'h00000a, 2'h0, 8'h04, 24'h000004, 2'h0);
      rows[1] = mk(1'h0, 1'h1, 16'h0003, 24'h00000a, 2'h0, 8'h07, 24'h000002, 2'h0);
      rows[2] = mk(1'h1, 1'h0, 16'h0001, 24'h000005, 2'h0, 8'h03, 24'h000002, 2'h0);
      rows[3] = mk(1'h0, 1'h0, 16'h0001, 24'h000003, 2'h1, 8'h05, 24'h000003, 2'h2);
      rows[4] = mk(1'h1, 1'h1, 16'h0002, 24'h000002, 2'h2, 8'h06, 24'h000000, 2'h1);
      rows[5] = mk(1'h0, 1'h0, 16'h0000, 24'h000003, 2'h2, 8'h04, 24'h000003, 2'h2);
      rows[6] = mk(1'h1, 1'h0, 16'h0001, 24'h000003, 2'h1, 8'h04, 24'h000000, 2'h1);
      rows[7] = mk(1'h0, 1'h1, 16'h0001, 24'h00000a, 2'h0, 8'h05, 24'h000005, 2'h0);
      tick(8);
      i_sys_rst <= 1'b0;
      tick(3);
      foreach (rows[i]) begin
         rows[i].cfg.source = ppc_pkg::ppc_source_e'(i % 3);
         rows[i].cfg.decimal_point_position = 2'(i);
         rows[i].cfg.display_high_value = 20'h00064;
         set_cfg(rows[i].cfg);
         hold(rows[i].cfg.count_down ? rows[i].cfg.upper_count_limit : 24'h000000);
         pulses(rows[i].num);
         check(count === rows[i].cnt, "count");
         check(over === rows[i].ovr && under === rows[i].und, "range flags");
         tick(100);
         q = rows[i].cnt * 48'h64 / rows[i].cfg.upper_count_limit;
         e = rows[i].cfg.range_limit_mode == ppc_pkg::PPC_LIMIT_ERROR
             && (rows[i].ovr || rows[i].und);
         check(disp.value === q[19:0], "display value");
         check(disp.decimal_point_position === rows[i].cfg.decimal_point_position, "point");
         check(disp.error === e, "error mark");
      end
      // pulses while the contact holds, then resume from zero
      set_cfg(rows[0].cfg);
      i_reset_contact_n <= 1'b0;
      tick(4);
      pulses(8'h03);
      check(count === 24'h000000, "held during pulses");
      i_reset_contact_n <= 1'b1;
      tick(4);
      pulses(8'h02);
      check(count === 24'h000002, "resume after hold");
      do_reset(1'b0, 24'h000055);
      check(count === 24'h000000 && menu === ppc_pkg::PPC_MENU_INPUT_TYPE, "reset state");
      check(cfg.divisor === ppc_pkg::DIV_RST, "divisor reset");
      check(cfg.upper_count_limit === ppc_pkg::LIMIT_RST, "limit reset");
      check(cfg.display_high_value === ppc_pkg::DISP_HI_RST, "display high reset");
      check(cfg.range_limit_mode === ppc_pkg::PPC_LIMIT_OFF, "limit mode reset");
      check(cfg.count_down === 1'b0, "direction reset");
      do_reset(1'b1, 24'h000123);
      check(count === 24'h000123, "restored count");
      pulses(8'h01);
      check(count === 24'h000124, "count after restore");
      do_reset(1'b1, 24'hfffffe);
      pulses(8'h03);
      check(count === 24'hffffff, "absolute maximum");
      tick(100);
      check(disp.error === 1'b1, "maximum marked");
      close_out();
   end
endmodule
bind ppc_counter ppc_counter_asserts chk (
   .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_pulse_pin(i_pulse_pin),
   .i_reset_contact_n(i_reset_contact_n), .i_menu_confirm(i_menu_confirm),
   .o_menu_entry(o_menu_entry), .o_cfg(o_cfg), .o_count(o_count),
   .o_retain_write(o_retain_write), .o_over_range(o_over_range), .o_under_range(o_under_range)
);
